/* acc_params.svh */
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

`define ACC_ADDR_CTRL0 8'h9b
`define ACC_ADDR_MODE0 8'h9d
`define ACC_ADDR_MUX0 8'h9f
`define ACC_ADDR_CTRL1 8'h9a
`define ACC_ADDR_MODE1 8'h9c
`define ACC_ADDR_MUX1 8'h9e

`define ACC_CTRL_ON_BIT 7
`define ACC_CTRL_RESULT_BIT 6
`define ACC_CTRL_RISE_BIT 5
`define ACC_CTRL_FALL_BIT 4
`define ACC_CTRL_PHYS_HI 3
`define ACC_CTRL_PHYS_LO 2
`define ACC_CTRL_NHYS_HI 1
`define ACC_CTRL_NHYS_LO 0

`define ACC_MODE_RIE_BIT 5
`define ACC_MODE_FIE_BIT 4
`define ACC_MODE_SPD_HI 1
`define ACC_MODE_SPD_LO 0

`define ACC_MUX_NSEL_HI 6
`define ACC_MUX_NSEL_LO 4
`define ACC_MUX_PSEL_HI 2
`define ACC_MUX_PSEL_LO 0

`define ACC_HYST_RESET 2'h0
`define ACC_SPEED_RESET 2'h2
`define ACC_SEL_RESET 3'h0
`define ACC_SEL_MAX_VALID 3'h4

`endif

/* acc_pkg.sv */
package acc_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acc_bus_req_t;

    typedef struct packed {
        logic on;
        logic [1:0] pos_hyst_sel;
        logic [1:0] neg_hyst_sel;
        logic [1:0] response_speed_sel;
        logic [2:0] pos_input_sel;
        logic [2:0] neg_input_sel;
        logic pos_valid;
        logic neg_valid;
    } acc_analog_cfg_t;

    typedef enum logic [1:0] {
        ACC_SYNC_IDLE = 2'b01,
        ACC_SYNC_RUN = 2'b10
    } acc_sync_state_t;

endpackage

/* acc_channel.sv */
`include "acc_params.svh"

module acc_channel (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic raw_i,
    input wire logic on_i,
    input wire logic clr_rise_i,
    input wire logic clr_fall_i,
    output logic sync_o,
    output logic rise_flag_o,
    output logic fall_flag_o
);
    import acc_pkg::*;

    typedef struct packed {
        acc_sync_state_t st;
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } acc_ch_state_t;

    acc_ch_state_t q;
    acc_ch_state_t next_q;

    always_comb begin
        next_q = q;
        // Only the second stage looks at the first stage.
        // Gating by the enable means powering up or down can look like an edge.
        next_q.s1 = raw_i & on_i;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // Skip the first compare after reset, in the idle state, so reset values make no edge.
        case (q.st)
            ACC_SYNC_IDLE: begin
                next_q.st = ACC_SYNC_RUN;
            end
            ACC_SYNC_RUN: begin
                // Set wins over a clear in the same cycle.
                next_q.rise = (q.s2 & ~q.s3) | (q.rise & ~clr_rise_i);
                next_q.fall = (~q.s2 & q.s3) | (q.fall & ~clr_fall_i);
            end
            default: begin
                next_q.st = ACC_SYNC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: ACC_SYNC_IDLE, default: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign sync_o = q.s2;
    assign rise_flag_o = q.rise;
    assign fall_flag_o = q.fall;
endmodule

/* acc_top.sv */
// Functional notes
// - Comparator powered only while comparator_on set.
// - Disabled: outputs low, supply cut.
// - Control bit 6 reads live result.
// - Falling edge sets fall_flag bit 4.
// - Rising edge sets rise_flag bit 5.
// - Flags stay set until software writes 0.
// - rise_irq_en gates rise_flag interrupt.
// - fall_irq_en gates fall_flag interrupt.
// - One interrupt per comparator, either edge.
// - Positive hysteresis select, control bits 3:2.
// - Negative hysteresis select, control bits 1:0.
// - Positive input select mux bits 2:0.
// - Negative input select mux bits 6:4.
// - Comparator zero at 0x9b, 0x9d, 0x9f.
// - Synchronised and raw outputs both offered.
// - Comparator zero exports reset and kill.
// - Spurious flags possible on power or mode.
// - Comparator one at 0x9a, 0x9c, 0x9e.
`include "acc_params.svh"

module acc_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input acc_pkg::acc_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire logic cmp_zero_raw_i,
    input wire logic cmp_one_raw_i,
    output acc_pkg::acc_analog_cfg_t cfg_zero_o,
    output acc_pkg::acc_analog_cfg_t cfg_one_o,
    output logic cmp_zero_async_o,
    output logic cmp_zero_sync_o,
    output logic cmp_one_async_o,
    output logic cmp_one_sync_o,
    output logic irq_zero_o,
    output logic irq_one_o,
    output logic reset_src_o,
    output logic counter_array_kill_o
);
    import acc_pkg::*;

    typedef struct packed {
        logic on;
        logic [1:0] phys;
        logic [1:0] nhys;
        logic rie;
        logic fie;
        logic [1:0] spd;
        logic [2:0] psel;
        logic [2:0] nsel;
    } acc_regs_t;

    typedef struct packed {
        acc_regs_t r0;
        acc_regs_t r1;
        logic [7:0] rdata;
        logic rvalid;
        logic irq0;
        logic irq1;
        logic async0;
        logic async1;
        logic sync0;
        logic sync1;
        acc_analog_cfg_t cfg0;
        acc_analog_cfg_t cfg1;
    } acc_top_state_t;

    acc_top_state_t q;
    acc_top_state_t next_q;

    logic sync0_w;
    logic sync1_w;
    logic rise0_w;
    logic fall0_w;
    logic rise1_w;
    logic fall1_w;
    logic clr_rise0;
    logic clr_fall0;
    logic clr_rise1;
    logic clr_fall1;
    logic wr_ctrl0;
    logic wr_ctrl1;

    function automatic acc_regs_t reg_write(input acc_regs_t r, input logic [7:0] addr,
                                            input logic [7:0] d, input logic [7:0] a_ctrl,
                                            input logic [7:0] a_mode, input logic [7:0] a_mux);
        acc_regs_t n;
        n = r;
        if (addr == a_ctrl) begin
            n.on = d[`ACC_CTRL_ON_BIT];
            n.phys = d[`ACC_CTRL_PHYS_HI:`ACC_CTRL_PHYS_LO];
            n.nhys = d[`ACC_CTRL_NHYS_HI:`ACC_CTRL_NHYS_LO];
        end
        if (addr == a_mode) begin
            n.rie = d[`ACC_MODE_RIE_BIT];
            n.fie = d[`ACC_MODE_FIE_BIT];
            n.spd = d[`ACC_MODE_SPD_HI:`ACC_MODE_SPD_LO];
        end
        if (addr == a_mux) begin
            n.psel = d[`ACC_MUX_PSEL_HI:`ACC_MUX_PSEL_LO];
            n.nsel = d[`ACC_MUX_NSEL_HI:`ACC_MUX_NSEL_LO];
        end
        return n;
    endfunction

    // Reserved bits are not stored and read as zero, so careless writes to them are harmless.
    function automatic logic [7:0] reg_read(input acc_regs_t r, input logic res,
                                            input logic rf, input logic ff,
                                            input logic [1:0] which);
        logic [7:0] v;
        v = 8'h00;
        case (which)
            2'd0: begin
                v[`ACC_CTRL_ON_BIT] = r.on;
                v[`ACC_CTRL_RESULT_BIT] = res;
                v[`ACC_CTRL_RISE_BIT] = rf;
                v[`ACC_CTRL_FALL_BIT] = ff;
                v[`ACC_CTRL_PHYS_HI:`ACC_CTRL_PHYS_LO] = r.phys;
                v[`ACC_CTRL_NHYS_HI:`ACC_CTRL_NHYS_LO] = r.nhys;
            end
            2'd1: begin
                v[`ACC_MODE_RIE_BIT] = r.rie;
                v[`ACC_MODE_FIE_BIT] = r.fie;
                v[`ACC_MODE_SPD_HI:`ACC_MODE_SPD_LO] = r.spd;
            end
            2'd2: begin
                v[`ACC_MUX_PSEL_HI:`ACC_MUX_PSEL_LO] = r.psel;
                v[`ACC_MUX_NSEL_HI:`ACC_MUX_NSEL_LO] = r.nsel;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    function automatic acc_analog_cfg_t make_cfg(input acc_regs_t r);
        acc_analog_cfg_t c;
        c.on = r.on;
        c.pos_hyst_sel = r.phys;
        c.neg_hyst_sel = r.nhys;
        c.response_speed_sel = r.spd;
        c.pos_input_sel = r.psel;
        c.neg_input_sel = r.nsel;
        // Reserved codes connect no channel.
        c.pos_valid = (r.psel <= `ACC_SEL_MAX_VALID);
        c.neg_valid = (r.nsel <= `ACC_SEL_MAX_VALID);
        return c;
    endfunction

    assign wr_ctrl0 = bus_i.wr && (bus_i.addr == `ACC_ADDR_CTRL0);
    assign wr_ctrl1 = bus_i.wr && (bus_i.addr == `ACC_ADDR_CTRL1);
    assign clr_rise0 = wr_ctrl0 && !bus_i.wdata[`ACC_CTRL_RISE_BIT];
    assign clr_fall0 = wr_ctrl0 && !bus_i.wdata[`ACC_CTRL_FALL_BIT];
    assign clr_rise1 = wr_ctrl1 && !bus_i.wdata[`ACC_CTRL_RISE_BIT];
    assign clr_fall1 = wr_ctrl1 && !bus_i.wdata[`ACC_CTRL_FALL_BIT];

    acc_channel u_ch0 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i(cmp_zero_raw_i),
        .on_i(q.r0.on),
        .clr_rise_i(clr_rise0),
        .clr_fall_i(clr_fall0),
        .sync_o(sync0_w),
        .rise_flag_o(rise0_w),
        .fall_flag_o(fall0_w)
    );

    acc_channel u_ch1 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i(cmp_one_raw_i),
        .on_i(q.r1.on),
        .clr_rise_i(clr_rise1),
        .clr_fall_i(clr_fall1),
        .sync_o(sync1_w),
        .rise_flag_o(rise1_w),
        .fall_flag_o(fall1_w)
    );

    always_comb begin
        next_q = q;
        next_q.rvalid = 1'b0;
        if (bus_i.wr) begin
            next_q.r0 = reg_write(q.r0, bus_i.addr, bus_i.wdata,
                                  `ACC_ADDR_CTRL0, `ACC_ADDR_MODE0, `ACC_ADDR_MUX0);
            next_q.r1 = reg_write(q.r1, bus_i.addr, bus_i.wdata,
                                  `ACC_ADDR_CTRL1, `ACC_ADDR_MODE1, `ACC_ADDR_MUX1);
        end
        if (bus_i.rd) begin
            next_q.rvalid = 1'b1;
            // The result bit reads the synchronised value, so it never samples a metastable level.
            case (bus_i.addr)
                `ACC_ADDR_CTRL0: next_q.rdata = reg_read(q.r0, sync0_w, rise0_w, fall0_w, 2'd0);
                `ACC_ADDR_MODE0: next_q.rdata = reg_read(q.r0, sync0_w, rise0_w, fall0_w, 2'd1);
                `ACC_ADDR_MUX0: next_q.rdata = reg_read(q.r0, sync0_w, rise0_w, fall0_w, 2'd2);
                `ACC_ADDR_CTRL1: next_q.rdata = reg_read(q.r1, sync1_w, rise1_w, fall1_w, 2'd0);
                `ACC_ADDR_MODE1: next_q.rdata = reg_read(q.r1, sync1_w, rise1_w, fall1_w, 2'd1);
                `ACC_ADDR_MUX1: next_q.rdata = reg_read(q.r1, sync1_w, rise1_w, fall1_w, 2'd2);
                default: next_q.rdata = 8'h00;
            endcase
        end
        next_q.irq0 = (rise0_w & q.r0.rie) | (fall0_w & q.r0.fie);
        next_q.irq1 = (rise1_w & q.r1.rie) | (fall1_w & q.r1.fie);
        // The raw copy is gated low while off; it lags the input by one register stage.
        next_q.async0 = cmp_zero_raw_i & q.r0.on;
        next_q.async1 = cmp_one_raw_i & q.r1.on;
        next_q.sync0 = sync0_w & q.r0.on;
        next_q.sync1 = sync1_w & q.r1.on;
        next_q.cfg0 = make_cfg(q.r0);
        next_q.cfg1 = make_cfg(q.r1);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.r0.spd <= `ACC_SPEED_RESET;
            q.r1.spd <= `ACC_SPEED_RESET;
            q.cfg0.response_speed_sel <= `ACC_SPEED_RESET;
            q.cfg1.response_speed_sel <= `ACC_SPEED_RESET;
            q.cfg0.pos_valid <= 1'b1;
            q.cfg0.neg_valid <= 1'b1;
            q.cfg1.pos_valid <= 1'b1;
            q.cfg1.neg_valid <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;
    assign rvalid_o = q.rvalid;
    assign cfg_zero_o = q.cfg0;
    assign cfg_one_o = q.cfg1;
    assign cmp_zero_async_o = q.async0;
    assign cmp_zero_sync_o = q.sync0;
    assign cmp_one_async_o = q.async1;
    assign cmp_one_sync_o = q.sync1;
    assign irq_zero_o = q.irq0;
    assign irq_one_o = q.irq1;
    assign reset_src_o = q.sync0;
    assign counter_array_kill_o = q.sync0;
endmodule

/* acc_top_asserts.sv */
module acc_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input acc_pkg::acc_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic cmp_zero_raw_i,
    input acc_pkg::acc_analog_cfg_t cfg_zero_o,
    input wire logic cmp_zero_async_o,
    input wire logic cmp_zero_sync_o,
    input wire logic irq_zero_o,
    input wire logic reset_src_o,
    input wire logic counter_array_kill_o
);
    import acc_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_RD_ANSWER: assert property (bus_i.rd |=> rvalid_o)
        else $error("read not answered");
    AST_NO_EXTRA: assert property (!bus_i.rd |=> !rvalid_o)
        else $error("answer without read");
    AST_UNMAPPED: assert property (rvalid_o && !($past(bus_i.addr) inside {[8'h9a:8'h9f]})
        |-> rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_MODE_RSVD: assert property (rvalid_o && $past(bus_i.addr) == 8'h9d
        |-> (rdata_o & 8'hcc) == 8'h00) else $error("mode reserved bits set");
    AST_CTRL_CFG: assert property ((bus_i.wr && bus_i.addr == 8'h9b) ##1
        !(bus_i.wr && bus_i.addr == 8'h9b) |=> cfg_zero_o.on == $past(bus_i.wdata[7], 2)
        && {cfg_zero_o.pos_hyst_sel, cfg_zero_o.neg_hyst_sel} == $past(bus_i.wdata[3:0], 2))
        else $error("control not applied");
    AST_MUX_CFG: assert property ((bus_i.wr && bus_i.addr == 8'h9f) ##1
        !(bus_i.wr && bus_i.addr == 8'h9f) |=> cfg_zero_o.pos_input_sel == $past(bus_i.wdata[2:0], 2)
        && cfg_zero_o.neg_input_sel == $past(bus_i.wdata[6:4], 2)) else $error("select not applied");
    AST_SPEED_CFG: assert property ((bus_i.wr && bus_i.addr == 8'h9d) ##1
        !(bus_i.wr && bus_i.addr == 8'h9d) |=> cfg_zero_o.response_speed_sel
        == $past(bus_i.wdata[1:0], 2)) else $error("speed not applied");
    AST_SEL_VALID: assert property (cfg_zero_o.pos_valid == (cfg_zero_o.pos_input_sel <= 3'h4)
        && cfg_zero_o.neg_valid == (cfg_zero_o.neg_input_sel <= 3'h4)) else $error("valid flag wrong");
    AST_OFF_LOW: assert property (!cfg_zero_o.on [*3] |-> !cmp_zero_async_o && !cmp_zero_sync_o)
        else $error("output high while off");
    AST_ASYNC: assert property (cfg_zero_o.on [*3] |-> cmp_zero_async_o == $past(cmp_zero_raw_i))
        else $error("async copy wrong");
    AST_SYNC: assert property ((cfg_zero_o.on && $stable(cmp_zero_raw_i)) [*5]
        |-> cmp_zero_sync_o == cmp_zero_raw_i) else $error("sync copy wrong");
    AST_EXPORT: assert property (reset_src_o == counter_array_kill_o && (reset_src_o ==
        cmp_zero_sync_o || reset_src_o == $past(cmp_zero_sync_o))) else $error("export wrong");
    AST_IRQ_OFF: assert property (bus_i.wr && bus_i.addr == 8'h9d && bus_i.wdata[5:4] == 2'h0
        |=> ##1 !irq_zero_o) else $error("masked interrupt raised");
endmodule

/* acc_cpu_model.sv */
module acc_cpu_model (
    input wire logic clk_sys_i,
    output acc_pkg::acc_bus_req_t bus_o
);
    import acc_pkg::*;
    initial bus_o = '0;
    // One access per call; the idle cycle after it keeps fields from being driven twice at one edge.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 8'h9c || a == 8'h9d) ? 8'h33 : (a == 8'h9e || a == 8'h9f) ? 8'h77 : 8'hff;
        @(negedge clk_sys_i);
        bus_o = '{wr: w, rd: !w, addr: a, wdata: d & m};
        @(negedge clk_sys_i);
        bus_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* test_analog_comparator_control.sv */
module test_analog_comparator_control;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] raw = 2'b00;
    acc_bus_req_t bus;
    logic [7:0] rdata;
    logic rvalid;
    acc_analog_cfg_t cfg0, cfg1;
    acc_analog_cfg_t cx;
    logic [1:0] async_o, sync_o, irq;
    logic rst_src, kill;
    logic [15:0] expq[$];
    logic [15:0] e;
    logic [7:0] v;
    logic [7:0] ac[2] = '{8'h9b, 8'h9a};
    logic [7:0] ad[2] = '{8'h9d, 8'h9c};
    logic [7:0] ax[2] = '{8'h9f, 8'h9e};
    int n_mismatch = 0;
    int n_tests = 0;
    integer seed = 90952;

    always #12.5 clk_sys_i = ~clk_sys_i;

    acc_top u_acc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
        .rvalid_o(rvalid), .cmp_zero_raw_i(raw[0]), .cmp_one_raw_i(raw[1]), .cfg_zero_o(cfg0),
        .cfg_one_o(cfg1), .cmp_zero_async_o(async_o[0]), .cmp_zero_sync_o(sync_o[0]),
        .cmp_one_async_o(async_o[1]), .cmp_one_sync_o(sync_o[1]), .irq_zero_o(irq[0]),
        .irq_one_o(irq[1]), .reset_src_o(rst_src), .counter_array_kill_o(kill));
    acc_cpu_model u_acc_cpu_model (.clk_sys_i(clk_sys_i), .bus_o(bus));

    task automatic stop_test;
        if (expq.size() != 0) begin
            n_mismatch++;
            $display("mismatch at %0t: read never answered", $time);
        end
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic c);
        n_tests++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: output level wrong", $time);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_acc_cpu_model.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        expq.push_back({m, x & m});
        u_acc_cpu_model.access(1'b0, a, 8'h00);
    endtask

    // Sampled mid-cycle so the answer is looked at while it stands, away from the edge.
    always @(negedge clk_sys_i) begin
        if (rvalid === 1'b1) begin
            n_tests++;
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("mismatch at %0t: read answer without request", $time);
            end else begin
                e = expq.pop_front();
                if ((rdata & e[15:8]) !== e[7:0]) begin
                    n_mismatch++;
                    $display("mismatch at %0t: read data %h", $time, rdata);
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_n_i = 1'b1;
        rd(8'ha0, 8'hff, 8'h00);
        for (int i = 0; i < 2; i++) begin
            rd(ac[i], 8'hff, 8'h00);
            rd(ad[i], 8'hff, 8'h02);
            rd(ax[i], 8'hff, 8'h00);
            repeat (4) begin
                v = 8'($random(seed));
                wr(ax[i], v);
                rd(ax[i], 8'hff, v & 8'h77);
                wr(ad[i], v & 8'h03);
                rd(ad[i], 8'hff, v & 8'h03);
                wr(ac[i], v & 8'h0f);
                rd(ac[i], 8'h8f, v & 8'h0f);
                cx = (i == 0) ? cfg0 : cfg1;
                chk(cx.pos_input_sel === v[2:0] && cx.neg_input_sel === v[6:4]);
                chk(cx.pos_valid === (v[2:0] <= 3'h4) && cx.neg_valid === (v[6:4] <= 3'h4));
                chk(cx.response_speed_sel === v[1:0]);
                chk(cx.pos_hyst_sel === v[3:2] && cx.neg_hyst_sel === v[1:0] && cx.on === 1'b0);
            end
            // Flags may be left over from power-up, so they are cleared before the mask opens.
            wr(ac[i], 8'h80);
            wr(ac[i], 8'h80);
            wr(ad[i], 8'h20);
            @(negedge clk_sys_i) raw[i] = 1'b1;
            repeat (6) @(negedge clk_sys_i);
            chk(irq[i] === 1'b1);
            rd(ac[i], 8'hff, 8'he0);
            raw[i] = 1'b0;
            repeat (6) @(negedge clk_sys_i);
            rd(ac[i], 8'hff, 8'hb0);
            wr(ad[i], 8'h00);
            repeat (3) @(negedge clk_sys_i);
            chk(irq[i] === 1'b0);
            wr(ad[i], 8'h10);
            repeat (3) @(negedge clk_sys_i);
            chk(irq[i] === 1'b1);
            wr(ac[i], 8'h90);
            rd(ac[i], 8'hff, 8'h90);
            wr(ac[i], 8'h80);
            repeat (3) @(negedge clk_sys_i);
            chk(irq[i] === 1'b0);
        end
        raw = 2'b11;
        repeat (6) @(negedge clk_sys_i);
        chk(async_o === 2'b11 && sync_o === 2'b11);
        chk(rst_src === 1'b1 && kill === 1'b1);
        wr(ac[0], 8'h00);
        wr(ac[1], 8'h00);
        repeat (4) @(negedge clk_sys_i);
        chk(async_o === 2'b00 && sync_o === 2'b00 && cfg0.on === 1'b0 && cfg1.on === 1'b0);
        repeat (4) @(negedge clk_sys_i);
        stop_test();
    end
endmodule

bind acc_top acc_checker u_acc_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cmp_zero_raw_i(cmp_zero_raw_i),
    .cfg_zero_o(cfg_zero_o), .cmp_zero_async_o(cmp_zero_async_o),
    .cmp_zero_sync_o(cmp_zero_sync_o), .irq_zero_o(irq_zero_o), .reset_src_o(reset_src_o),
    .counter_array_kill_o(counter_array_kill_o));
